// File: design/irs_unit.sv
// register select logic of one interrupt unit on the x bus
// assumes one-cycle read and write strobes synchronous to clk
`timescale 1ns/10ps
module irs_unit
#(
    parameter logic [7:0] BASE_ADDR = irs_pkg::IRS_BASE_FIRST
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    // x bus cycle
    input  wire logic [7:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic [7:0]      io_rdata,
    output logic            io_rdata_valid,
    // interrupt request lines
    input  wire logic [7:0] request_lines,
    output logic            int_req
);
    import irs_pkg::*;

    if ((BASE_ADDR != IRS_BASE_FIRST) && (BASE_ADDR != IRS_BASE_SECOND))
    begin : g_chk
        $error("irs_unit: base address must be one of the two unit addresses");
    end

    logic [7:0] pending_request_reg;
    logic [7:0] in_service_reg;
    logic [7:0] mask_reg;
    logic [7:0] request_prev;
    logic       read_sel;
    logic       poll_pending;
    logic       init_active;

    logic       hit;
    logic       address_bit_zero;
    logic       data_bit_four;
    logic       data_bit_three;
    logic       wr_even;
    logic       wr_odd;
    logic       rd_even;
    logic       rd_odd;
    logic       second_op_wr;
    logic       third_op_wr;
    logic       first_init_wr;
    logic       mask_wr;
    logic       poll_read;
    logic       poll_ack;
    logic       poll_found;
    logic [2:0] poll_level_code;
    logic       svc_found;
    logic [2:0] svc_level;
    logic [7:0] poll_result_reg;
    logic [7:0] ack_vec;
    logic [7:0] end_int_vec;
    logic [7:0] rise_vec;
    logic [7:0] next_pending;
    logic [7:0] next_service;

    // unit decode at the shared even address and its odd neighbour
    assign hit              = (io_addr & IRS_ADDR_MASK) == BASE_ADDR; // RULE_14
    assign address_bit_zero = io_addr[IRS_ADDR_LSB];
    assign data_bit_four    = io_wdata[IRS_SEL_HI_BIT];
    assign data_bit_three   = io_wdata[IRS_SEL_LO_BIT];
    assign wr_even          = io_wr & hit & ~address_bit_zero;
    assign wr_odd           = io_wr & hit & address_bit_zero;
    assign rd_even          = io_rd & hit & ~address_bit_zero;
    assign rd_odd           = io_rd & hit & address_bit_zero;

    // even write steering by data bits four and three
    assign second_op_wr  = wr_even & ~data_bit_four & ~data_bit_three; // RULE_11
    assign third_op_wr   = wr_even & ~data_bit_four & data_bit_three; // RULE_11
    assign first_init_wr = wr_even & data_bit_four; // RULE_11
    assign mask_wr       = wr_odd & ~init_active; // RULE_12

    // init word sequencing for odd writes
    irs_init_seq u_init
    (
        .clk           (clk),
        .sys_rst       (sys_rst),
        .clk_en        (clk_en),
        .first_init_wr (first_init_wr),
        .odd_wr        (wr_odd),
        .wdata         (io_wdata),
        .init_active   (init_active)
    );

    // highest unmasked pending level for the poll word
    irs_prio_enc #(.WIDTH(8), .LVL_W(3)) u_poll_enc
    (
        .vec   (pending_request_reg & ~mask_reg),
        .found (poll_found),
        .level (poll_level_code)
    );

    // highest level in service for a nonspecific end of interrupt
    irs_prio_enc #(.WIDTH(8), .LVL_W(3)) u_svc_enc
    (
        .vec   (in_service_reg),
        .found (svc_found),
        .level (svc_level)
    );

    // poll word: flag, undefined middle read as zero, level or all ones
    assign poll_result_reg = {poll_found, IRS_POLL_FILL, // RULE_09
                              poll_found ? poll_level_code : IRS_LEVEL_NONE}; // RULE_10

    // poll read acknowledges the polled level
    assign poll_read = rd_even & poll_pending;
    assign poll_ack  = poll_read & poll_found; // RULE_17
    assign ack_vec   = poll_ack ? (IRS_ONE_HOT << poll_level_code) : IRS_BYTE_ZERO;

    // end of interrupt picks a specific or the highest serviced level
    always_comb
    begin
        end_int_vec = IRS_BYTE_ZERO;
        if (second_op_wr && io_wdata[IRS_END_INT_BIT])
        begin
            if (io_wdata[IRS_SPECIFIC_BIT])
                end_int_vec = IRS_ONE_HOT << io_wdata[IRS_LVL_HI:IRS_LVL_LO]; // RULE_08
            else if (svc_found)
                end_int_vec = IRS_ONE_HOT << svc_level; // RULE_08
        end
    end

    // pending bits follow their lines, a fresh edge beats the acknowledge
    assign rise_vec     = request_lines & ~request_prev;
    assign next_pending = (pending_request_reg | rise_vec) & request_lines & ~(ack_vec & ~rise_vec); // RULE_06
    // service bits: acknowledge wins over an end of interrupt clear in the same cycle, the first init word clears all
    assign next_service = first_init_wr ? IRS_BYTE_ZERO : ((in_service_reg & ~end_int_vec) | ack_vec); // RULE_07

    // request edge history and pending bits
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            request_prev        <= IRS_BYTE_ZERO;
            pending_request_reg <= IRS_BYTE_ZERO;
        end
        else if (clk_en)
        begin
            request_prev        <= request_lines;
            pending_request_reg <= next_pending; // RULE_06
        end
    end

    // service bits
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            in_service_reg <= IRS_BYTE_ZERO;
        else if (clk_en)
            in_service_reg <= next_service; // RULE_07 RULE_08 RULE_17
    end

    // interrupt mask, cleared by the first init word
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            mask_reg <= IRS_MASK_RST;
        else if (clk_en)
        begin
            if (first_init_wr)
                mask_reg <= IRS_MASK_RST;
            else if (mask_wr)
                mask_reg <= io_wdata; // RULE_12
        end
    end

    // read source choice and pending poll
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            read_sel     <= IRS_SRC_PENDING; // RULE_05
            poll_pending <= 1'b0;
        end
        else if (clk_en)
        begin
            if (first_init_wr)
            begin
                read_sel     <= IRS_SRC_PENDING; // RULE_05
                poll_pending <= 1'b0;
            end
            else if (third_op_wr)
            begin
                // a poll forces read enable off, so the choice stays
                if (io_wdata[IRS_POLL_BIT])
                    poll_pending <= 1'b1; // RULE_01 RULE_16
                else
                begin
                    poll_pending <= 1'b0;
                    if (io_wdata[IRS_READ_EN_BIT])
                        read_sel <= io_wdata[IRS_READ_SEL_BIT]; // RULE_04 RULE_15
                end
            end
            else if (rd_even || rd_odd)
                poll_pending <= 1'b0; // RULE_02
        end
    end

    // read data and its valid flag
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            io_rdata       <= IRS_BYTE_ZERO;
            io_rdata_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            io_rdata_valid <= rd_even | rd_odd;
            if (rd_odd)
                io_rdata <= mask_reg; // RULE_13
            else if (rd_even && poll_pending)
                io_rdata <= poll_result_reg; // RULE_13 RULE_01
            else if (rd_even)
                io_rdata <= read_sel ? in_service_reg : pending_request_reg; // RULE_13 RULE_03
        end
    end

    // any unmasked request raises the interrupt line
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            int_req <= 1'b0;
        else if (clk_en)
            int_req <= |(pending_request_reg & ~mask_reg);
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_poll_cmd;
        clk_en && third_op_wr && io_wdata[IRS_POLL_BIT];
    endsequence

    sequence s_even_read;
        clk_en && rd_even && !io_wr;
    endsequence

    // an enabled cycle with no strobe, as between two host cycles
    sequence s_bus_idle;
        clk_en && !io_rd && !io_wr;
    endsequence

    // read choice command: read enable set, no poll
    sequence s_choose_cmd;
        clk_en && third_op_wr && !io_wdata[IRS_POLL_BIT] && io_wdata[IRS_READ_EN_BIT];
    endsequence

    poll_word_read_a: assert property ((s_even_read and poll_pending) // RULE_01 RULE_09 RULE_10
                                       |=> io_rdata == $past(poll_result_reg))
        else $error("poll word not returned");

    poll_cmd_then_read_a: assert property (s_poll_cmd ##1 s_bus_idle ##1 (s_even_read and !third_op_wr) // RULE_02
                                           |=> !poll_pending && io_rdata[IRS_POLL_INT_BIT] == $past(poll_found))
        else $error("poll not cancelled by read");

    poll_keeps_sel_a: assert property (s_poll_cmd |=> poll_pending && read_sel == $past(read_sel)) // RULE_16
        else $error("poll changed read choice");

    sel_hold_a: assert property ((clk_en && !third_op_wr && !first_init_wr) |=> read_sel == $past(read_sel)) // RULE_03
        else $error("read choice changed without command");

    sel_service_a: assert property ((s_choose_cmd and io_wdata[IRS_READ_SEL_BIT]) // RULE_04
                                    |=> ((read_sel == IRS_SRC_SERVICE)
                                    and (1'b1 |=> ((clk_en && rd_even && !poll_pending)
                                    |=> io_rdata == $past(in_service_reg)))))
        else $error("service register not chosen");

    sel_pending_a: assert property ((s_choose_cmd and !io_wdata[IRS_READ_SEL_BIT]) // RULE_15
                                    |=> ((read_sel == IRS_SRC_PENDING)
                                    and (1'b1 |=> ((clk_en && rd_even && !poll_pending)
                                    |=> io_rdata == $past(pending_request_reg)))))
        else $error("pending register not chosen");

    init_select_a: assert property ((clk_en && first_init_wr) // RULE_05
                                    |=> read_sel == IRS_SRC_PENDING && !poll_pending)
        else $error("init did not choose pending register");

    pending_line_a: assert property (clk_en // RULE_06
                                     |=> (pending_request_reg & ~$past(request_lines)) == IRS_BYTE_ZERO)
        else $error("pending bit without request line");

    pending_rise_a: assert property ((clk_en && (request_lines & ~request_prev) != IRS_BYTE_ZERO) // RULE_06
                                     |=> (pending_request_reg & $past(request_lines & ~request_prev))
                                         == $past(request_lines & ~request_prev))
        else $error("rising request not pending");

    end_int_clear_a: assert property ((clk_en && second_op_wr && io_wdata[IRS_END_INT_BIT] // RULE_08
                                       && io_wdata[IRS_SPECIFIC_BIT] && !poll_ack)
                                      |=> in_service_reg[$past(io_wdata[IRS_LVL_HI:IRS_LVL_LO])] == 1'b0)
        else $error("end of interrupt left service bit set");

    poll_ack_pend_a: assert property ((clk_en && poll_ack && !rise_vec[poll_level_code]) // RULE_17
                                      |=> !pending_request_reg[$past(poll_level_code)])
        else $error("poll read left pending bit set");

    odd_read_cancel_a: assert property ((clk_en && rd_odd) |=> !poll_pending) // RULE_02
        else $error("odd read left poll pending");

    poll_ack_a: assert property ((clk_en && poll_ack) |=> in_service_reg[$past(poll_level_code)]) // RULE_17 RULE_07
        else $error("poll read did not set service bit");

    mask_load_a: assert property ((clk_en && mask_wr && !first_init_wr) |=> mask_reg == $past(io_wdata)) // RULE_12
        else $error("mask not loaded");

    odd_read_a: assert property ((clk_en && rd_odd) |=> io_rdata_valid && io_rdata == $past(mask_reg)) // RULE_13
        else $error("odd read did not return mask");
endmodule

// File: design/irs_pkg.sv
// constants for the register select logic of one interrupt unit
// assumes an 8-bit x bus with one-cycle read and write strobes
//
// Functional notes
// [RULE_01] poll command: next even read returns poll word
// [RULE_02] first read after poll cancels the poll
// [RULE_03] even reads keep the latest chosen register
// [RULE_04] read enable plus select one picks service register
// [RULE_05] first init word or reset picks pending register
// [RULE_06] pending bit is one while its line requests; here set only on a rising edge and cleared by a poll acknowledge
// [RULE_07] service bit is one while level serviced
// [RULE_08] end of interrupt clears the matching service bit
// [RULE_09] poll bit 7 flags that a request was polled
// [RULE_10] poll bits 2-0 give level, ones if none
// [RULE_11] even write steered by data bits 4 and 3
// [RULE_12] odd write loads init words, then the mask
// [RULE_13] even read selected word, odd read mask
// [RULE_14] units sit at even addresses 020h and 0a0h
// [RULE_15] read enable plus select zero picks pending register
// [RULE_16] poll command forces read enable back to zero
// [RULE_17] poll read acknowledges the polled level
package irs_pkg;
    // unit base addresses on the x bus
    localparam logic [7:0] IRS_BASE_FIRST  = 8'h20;
    localparam logic [7:0] IRS_BASE_SECOND = 8'ha0;
    localparam logic [7:0] IRS_ADDR_MASK   = 8'hfe;
    localparam int         IRS_ADDR_LSB    = 0;
    // write steering bits
    localparam int IRS_SEL_HI_BIT = 4;
    localparam int IRS_SEL_LO_BIT = 3;
    // third operation word fields
    localparam int IRS_POLL_BIT     = 2;
    localparam int IRS_READ_EN_BIT  = 1;
    localparam int IRS_READ_SEL_BIT = 0;
    // second operation word fields
    localparam int IRS_END_INT_BIT  = 5;
    localparam int IRS_SPECIFIC_BIT = 6;
    localparam int IRS_LVL_HI       = 2;
    localparam int IRS_LVL_LO       = 0;
    // first init word fields
    localparam int IRS_SINGLE_BIT  = 1;
    localparam int IRS_NEED_W4_BIT = 0;
    // poll word layout
    localparam int         IRS_POLL_INT_BIT = 7;
    localparam logic [2:0] IRS_LEVEL_NONE   = 3'h7;
    localparam logic [3:0] IRS_POLL_FILL    = 4'h0;
    // reset values and one-hot seed
    localparam logic [7:0] IRS_BYTE_ZERO = 8'h00;
    localparam logic [7:0] IRS_ONE_HOT   = 8'h01;
    localparam logic [7:0] IRS_MASK_RST  = 8'h00;
    // read source choice
    localparam logic IRS_SRC_PENDING = 1'b0;
    localparam logic IRS_SRC_SERVICE = 1'b1;
    // init sequence states
    typedef enum logic [3:0]
    {
        IRS_INIT_DONE = 4'b0001,
        IRS_INIT_W2   = 4'b0010,
        IRS_INIT_W3   = 4'b0100,
        IRS_INIT_W4   = 4'b1000
    } irs_init_state_t;
endpackage

// File: design/irs_prio_enc.sv
// fixed priority encoder, bit 0 highest
// assumes a combinational consumer in the same clock domain
`timescale 1ns/10ps
module irs_prio_enc
#(
    parameter int WIDTH = 8,
    parameter int LVL_W = 3
)
(
    // request vector
    input  wire logic [WIDTH-1:0] vec,
    // result
    output logic                  found,
    output logic [LVL_W-1:0]      level
);
    import irs_pkg::*;

    if (WIDTH != (1 << LVL_W))
    begin : g_chk
        $error("irs_prio_enc: width must be two to the level width");
    end

    // scan from lowest priority so the highest one lands last
    always_comb
    begin
        found = 1'b0;
        level = '1;
        for (int i = WIDTH - 1; i >= 0; i--)
        begin
            if (vec[i])
            begin
                found = 1'b1;
                level = LVL_W'(i);
            end
        end
    end
endmodule

// File: design/irs_init_seq.sv
// tracks the initialization word sequence of one unit
// assumes strobes already decoded to this unit
`timescale 1ns/10ps
module irs_init_seq
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    // decoded writes
    input  wire logic       first_init_wr,
    input  wire logic       odd_wr,
    input  wire logic [7:0] wdata,
    // status
    output logic            init_active
);
    import irs_pkg::*;

    irs_init_state_t state;
    logic            single_mode;
    logic            need_fourth;

    assign init_active = (state != IRS_INIT_DONE);

    // word counter: second, optional third, optional fourth
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state       <= IRS_INIT_DONE;
            single_mode <= 1'b0;
            need_fourth <= 1'b0;
        end
        else if (clk_en)
        begin
            if (first_init_wr)
            begin
                state       <= IRS_INIT_W2;
                single_mode <= wdata[IRS_SINGLE_BIT];
                need_fourth <= wdata[IRS_NEED_W4_BIT];
            end
            else if (odd_wr)
            begin
                case (state)
                    IRS_INIT_W2:
                        state <= !single_mode ? IRS_INIT_W3 : (need_fourth ? IRS_INIT_W4 : IRS_INIT_DONE);
                    IRS_INIT_W3:
                        state <= need_fourth ? IRS_INIT_W4 : IRS_INIT_DONE;
                    IRS_INIT_W4:
                        state <= IRS_INIT_DONE;
                    IRS_INIT_DONE:
                        state <= IRS_INIT_DONE;
                    default:
                        state <= IRS_INIT_DONE;
                endcase
            end
        end
    end
endmodule

// File: sim/irs_host.sv
// host model issuing single-byte io cycles on the x bus
// assumes one-cycle strobes launched and released at falling edges
`timescale 1ns/10ps
module irs_host
(
    // clock
    input  wire logic       clk,
    // x bus cycle
    output logic [7:0]      io_addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic [7:0]      io_wdata,
    input  wire logic [7:0] io_rdata,
    input  wire logic       io_rdata_valid
);
    // idle bus at time zero
    initial
    begin
        io_addr  = 8'h00;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    // one write strobe, then address and data scrambled
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(negedge clk);
        io_wr    = 1'b0;
        io_addr  = ~a;
        io_wdata = ~d;
    endtask

    // one read strobe, answer taken a cycle later
    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk);
        io_addr = a;
        io_rd   = 1'b1;
        @(negedge clk);
        io_rd   = 1'b0;
        io_addr = ~a;
        v       = io_rdata_valid;
        d       = io_rdata;
    endtask
endmodule

// File: sim/tb_interrupt_unit_pair_register_select.sv
// self-checking bench for the register select logic of one unit
// assumes the host model drives the x bus at falling edges
`timescale 1ns/10ps
`define CHK(nm, ex, gt) \
    begin \
        n_compared++; \
        if ((gt) !== (ex)) \
        begin \
            $display("MISMATCH %s expected %h seen %h", nm, ex, gt); \
            errors++; \
        end \
    end
module tb_interrupt_unit_pair_register_select;
    import irs_pkg::*;
    localparam logic [7:0] EVN = IRS_BASE_FIRST;
    localparam logic [7:0] ODD = IRS_BASE_FIRST | 8'h01;
    logic       clk           = 1'b0;
    logic       sys_rst       = 1'b1;
    logic       clk_en        = 1'b1;
    logic [7:0] request_lines = 8'h00;
    logic [7:0] io_addr, io_wdata, io_rdata;
    logic       io_wr, io_rd, io_rdata_valid, int_req, sel, poll, v;
    logic [7:0] pend, serv, mask, prev, first_init_word, g;
    int         init_st, errors, n_compared, it, k, j, wd, seed;

    // 50 mhz clock
    always #10 clk = ~clk;

    irs_unit #(.BASE_ADDR(EVN)) uut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rdata_valid(io_rdata_valid), .request_lines(request_lines), .int_req(int_req));
    irs_host host (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid));

    // write, then step the reference model
    task automatic xwr(input logic [7:0] a, input logic [7:0] d);
        host.bus_wr(a, d);
        if (a[0])
        begin
            if (init_st == 2)
                init_st = !first_init_word[1] ? 3 : (first_init_word[0] ? 4 : 0);
            else if (init_st == 3)
                init_st = first_init_word[0] ? 4 : 0;
            else if (init_st == 4)
                init_st = 0;
            else
                mask = d;
        end
        else if (d[4])
        begin
            {serv, mask, sel, poll} = 18'h0;
            first_init_word = d;
            init_st = 2;
        end
        else if (d[3])
        begin
            poll = d[2];
            if (!d[2] && d[1])
                sel = d[0];
        end
        else if (d[5] && d[6])
            serv[d[2:0]] = 1'b0;
        else if (d[5])
            serv = serv & ~(serv & (~serv + 8'h01));
    endtask

    // read, predict from the model and compare
    task automatic xrd(input logic [7:0] a, input string nm);
        logic [7:0] u;
        logic [7:0] ex;
        logic       vd;
        int         lvl;
        u = pend & ~mask;
        lvl = 7;
        for (int i = 7; i >= 0; i--)
            if (u[i])
                lvl = i;
        if (a[0])
            ex = mask;
        else if (poll)
        begin
            ex = {|u, IRS_POLL_FILL, (|u) ? lvl[2:0] : IRS_LEVEL_NONE};
            if (|u)
            begin
                serv[lvl] = 1'b1;
                pend[lvl] = 1'b0;
            end
        end
        else
            ex = sel ? serv : pend;
        poll = 1'b0;
        host.bus_rd(a, g, vd);
        `CHK("read valid", 1'b1, vd)
        `CHK(nm, ex, g)
    endtask

    // drive request lines, pending is edge set and level held
    task automatic set_lines(input logic [7:0] l);
        @(negedge clk);
        request_lines = l;
        pend = (pend | (l & ~prev)) & l;
        prev = l;
        repeat (3) @(negedge clk);
        `CHK("int_req", |(pend & ~mask), int_req)
    endtask

    // verdict and end of run
    task automatic complete_run();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog against a hung run
    initial
    begin
        for (wd = 0; wd < 20000; wd++)
            @(posedge clk);
        errors++;
        complete_run();
    end

    // main sequence
    initial
    begin
        seed = $urandom(82);
        {pend, serv, mask, prev, sel, poll} = 34'h0;
        init_st = 0;
        errors = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        xrd(EVN, "reset even read");
        xrd(ODD, "reset mask read");
        host.bus_rd(8'h40, g, v);
        `CHK("foreign valid", 1'b0, v)
        host.bus_rd(IRS_BASE_SECOND, g, v);
        `CHK("second unit valid", 1'b0, v)
        // every init word layout, three odd writes each with a mask read
        for (k = 0; k < 4; k++)
        begin
            xwr(EVN, 8'h10 | k[7:0]);
            for (j = 0; j < 3; j++)
            begin
                xwr(ODD, 8'($urandom));
                xrd(ODD, "odd steering");
            end
        end
        // frozen clock enable ignores a write
        @(negedge clk);
        clk_en = 1'b0;
        host.bus_wr(ODD, ~mask);
        clk_en = 1'b1;
        xrd(ODD, "mask after freeze");
        for (it = 0; it < 40; it++)
        begin
            xwr(ODD, 8'($urandom & $urandom));
            set_lines(8'($urandom));
            xwr(EVN, 8'h0a);
            xrd(EVN, "pending read");
            xwr(EVN, it[0] ? 8'h0c : 8'h0f);
            xrd(EVN, "poll word");
            xrd(EVN, "after poll");
            xwr(EVN, 8'h0b);
            xrd(EVN, "service read");
            xwr(EVN, 8'h08);
            xrd(EVN, "read enable off keeps choice");
            xwr(EVN, 8'h0c);
            xrd(EVN, "second poll");
            xrd(EVN, "service kept");
            xwr(EVN, it[0] ? 8'h20 : (8'h60 | 8'($urandom % 8)));
            xrd(EVN, "after end of interrupt");
            if (it % 8 == 7)
            begin
                xwr(EVN, 8'h0c);
                xrd(ODD, "odd read during poll");
                xrd(EVN, "poll gone after odd read");
                xwr(EVN, 8'h1a);
                xrd(EVN, "init picks pending");
                xwr(ODD, 8'h55);
                set_lines(8'h00);
                xwr(EVN, 8'h0c);
                xrd(EVN, "empty poll");
            end
        end
        complete_run();
    end
endmodule
